// ---- design/sarcc_defines.vh ----
// Constants for the successive-approximation converter control block.
// Assumes one 10 MHz system clock and a plain address/strobe register port.
// ------------------------------------------------------------------
// Summary of operation
// [RQ1] Completion loads result, clears busy, sets flag
// [RQ2] Result register holds contents across resets
// [RQ3] Conversion lasts nine and a half bit periods
// [RQ4] Clock select picks 2, 8, 32 or RC
// [RQ5] Software keeps bit period at least 1.6 us
// [RQ6] Software waits two bit periods before acquiring
// [RQ7] Software allows acquisition time before any start
// [RQ8] Hold capacitor disconnects when conversion begins
// [RQ9] Software never starts in the enabling write
// [RQ10] Mode 1011 trigger starts conversion, clears timer
// [RQ11] Disabled converter ignores trigger, timer still cleared
// [RQ12] Analog pins read as zero on port
// [RQ13] Output-driven selected pin converts its own level
// [RQ14] Channel and direction bits never block sequencing
// [RQ15] Pin config plus direction set pin roles
// [RQ16] Software arms flag and enables before starting
// [RQ17] Software polls busy bit or waits flag
// [RQ18] Internal RC bit period typically 4 us
// [RQ19] Reset turns module off, aborts conversion
// [RQ20] Channel codes 000 to 011 only valid
// [RQ21] Busy bit reads one throughout a conversion
// ------------------------------------------------------------------
`ifndef SARCC_DEFINES_VH
`define SARCC_DEFINES_VH

// ------------------------------------------------------------------
// Register offsets
// ------------------------------------------------------------------
`define SARCC_OFS_PORT_A_PINS 8'h05
`define SARCC_OFS_IRQ_CONTROL 8'h0B
`define SARCC_OFS_IRQ_CONTROL_HI 8'h8B
`define SARCC_OFS_PERIPH_FLAGS 8'h0C
`define SARCC_OFS_CONV_RESULT 8'h1E
`define SARCC_OFS_CONV_CONTROL 8'h1F
`define SARCC_OFS_PORT_A_DIR 8'h85
`define SARCC_OFS_PERIPH_ENABLES 8'h8C
`define SARCC_OFS_PIN_CONFIG 8'h9F

// ------------------------------------------------------------------
// Reset values and writable masks
// ------------------------------------------------------------------
`define SARCC_RST_ZERO 8'h00
`define SARCC_RST_PORT_A_DIR 8'h1F
`define SARCC_MASK_PORT_A 8'h1F
`define SARCC_MASK_FLAGS 8'h47
`define SARCC_MASK_CONTROL 8'hFD
`define SARCC_MASK_PIN_CONFIG 8'h07

// ------------------------------------------------------------------
// Field positions
// ------------------------------------------------------------------
`define SARCC_CTL_CLKSEL_HI 7
`define SARCC_CTL_CLKSEL_LO 6
`define SARCC_CTL_CHAN_HI 5
`define SARCC_CTL_CHAN_LO 3
`define SARCC_CTL_GO 2
`define SARCC_CTL_ON 0
`define SARCC_FLAG_CONV 6
`define SARCC_CCU_MODE_TRIGGER 4'hB

// ------------------------------------------------------------------
// Timing
// ------------------------------------------------------------------
`define SARCC_SYS_CLK_NS 100
`define SARCC_RC_TAD_NS 4000
`define SARCC_HALF_TADS 5'h13
`define SARCC_SAMPLE_HALVES 5'h03
`define SARCC_HALF_DIV_2 8'h01
`define SARCC_HALF_DIV_8 8'h04
`define SARCC_HALF_DIV_32 8'h10

`endif

// ---- design/sarcc_tad_gen.v ----
// Bit-period generator: one-cycle pulse every half bit period.
// Assumes the oscillator period equals the system clock period.
`timescale 1ns/1ps
`include "sarcc_defines.vh"

module sarcc_tad_gen #(
  parameter RC_TAD_NS = `SARCC_RC_TAD_NS
) (
  // Clock and reset
  input wire clk,
  input wire resetn,
  // Control
  input wire run,
  input wire [1:0] clk_sel,
  // Half bit period pulse
  output reg half_tick
);

  // Half of the internal RC period in system cycles, rounded down
  localparam integer RC_HALF = RC_TAD_NS / (2 * `SARCC_SYS_CLK_NS);
  localparam [7:0] RC_HALF_DIV = RC_HALF[7:0];

  reg [7:0] cnt_reg;
  reg [7:0] div_len;

  // Divide ratio per select code
  always @* begin
    case (clk_sel)
      2'b00: div_len = `SARCC_HALF_DIV_2; // RQ4
      2'b01: div_len = `SARCC_HALF_DIV_8; // RQ4
      2'b10: div_len = `SARCC_HALF_DIV_32; // RQ4
      default: div_len = RC_HALF_DIV; // RQ18
    endcase
  end

  // Counter restarts when idle so every conversion starts aligned
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt_reg <= 8'h00;
      half_tick <= 1'b0;
    end else if (!run) begin
      cnt_reg <= 8'h00;
      half_tick <= 1'b0;
    end else if (cnt_reg + 8'h01 >= div_len) begin
      cnt_reg <= 8'h00;
      half_tick <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg + 8'h01;
      half_tick <= 1'b0;
    end
  end

endmodule // sarcc_tad_gen

// ---- design/sarcc_top.v ----
// Converter control: registers, port A pin roles, conversion sequencer.
// Assumes comparator and pins are asynchronous; trigger is on SYS_CLK.
//
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/1ps
`include "sarcc_defines.vh"

module sarcc_top #(
  parameter RC_TAD_NS = `SARCC_RC_TAD_NS
) (
  // Clock and reset
  input wire SYS_CLK,
  input wire RESETN,
  // Register port
  input wire [7:0] ADDR,
  input wire [7:0] WDATA,
  input wire WR,
  input wire RD,
  output reg [7:0] RDATA,
  // Port A pins
  input wire [4:0] PA_IN,
  output reg [4:0] PA_OUT,
  output reg [4:0] PA_OE,
  // Analog front end
  input wire COMP_IN,
  output reg [7:0] DAC_CODE,
  output reg [1:0] CHAN_SEL,
  output reg HOLD_CONNECT,
  output reg [3:0] ANALOG_EN,
  output reg VREF_EXT,
  // Capture/compare trigger and timer
  input wire CCU_TRIGGER,
  input wire [3:0] CCU_MODE,
  output reg TIMER_CLEAR
);

  // ------------------------------------------------------------------
  // Helper functions
  // ------------------------------------------------------------------

  // Analog mask for AN3..AN0 per pin config code
  function [3:0] analog_mask;
    input [2:0] cfg;
    begin
      case (cfg)
        3'h0: analog_mask = 4'hF;
        3'h1: analog_mask = 4'h7;
        3'h2: analog_mask = 4'h3;
        3'h3: analog_mask = 4'h3;
        3'h4: analog_mask = 4'h1;
        3'h5: analog_mask = 4'h1;
        default: analog_mask = 4'h0;
      endcase
    end
  endfunction

  // Codes using the pin three as external reference
  function ext_ref;
    input [2:0] cfg;
    begin
      ext_ref = (cfg == 3'h1) || (cfg == 3'h3) || (cfg == 3'h5);
    end
  endfunction

  // Write data with the non-writable bits forced to zero
  function [7:0] masked;
    input [7:0] data;
    input [7:0] mask;
    begin
      masked = data & mask;
    end
  endfunction

  // ------------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------------
  localparam ST_IDLE = 1'b0;
  localparam ST_CONV = 1'b1;

  reg [7:0] port_latch_reg;
  reg [7:0] port_a_direction_reg;
  reg [7:0] interrupt_control_reg;
  reg [7:0] peripheral_irq_flags_reg;
  reg [7:0] peripheral_irq_enables_reg;
  reg [7:0] converter_control_reg;
  reg [7:0] analog_pin_config_reg;
  reg [7:0] conversion_result_reg;
  reg state_reg;
  reg [4:0] half_cnt_reg;
  reg [7:0] sar_reg;
  reg [7:0] bit_mask_reg;
  reg [4:0] pa_meta_reg;
  reg [4:0] pa_sync_reg;
  reg comp_meta_reg;
  reg comp_sync_reg;

  reg state_next;
  reg [4:0] half_cnt_next;
  reg [7:0] sar_next;
  reg [7:0] bit_mask_next;
  reg [7:0] rdata_next;
  reg decide;
  reg comp_eff;
  reg done;

  wire half_tick;
  wire wr_ctl;
  wire conv_on;
  wire trig_match;
  wire sw_start;
  wire hw_start;
  wire start;
  wire [3:0] amask;
  wire [1:0] chan;
  wire chan_valid;
  wire pin_is_out;
  wire [4:0] port_read;

  // ------------------------------------------------------------------
  // Input synchronisers
  // ------------------------------------------------------------------

  // Pins and comparator are asynchronous to SYS_CLK
  always @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      pa_meta_reg <= 5'h00;
      pa_sync_reg <= 5'h00;
      comp_meta_reg <= 1'b0;
      comp_sync_reg <= 1'b0;
    end else begin
      pa_meta_reg <= PA_IN;
      pa_sync_reg <= pa_meta_reg;
      comp_meta_reg <= COMP_IN;
      comp_sync_reg <= comp_meta_reg;
    end
  end

  // ------------------------------------------------------------------
  // Start and trigger decode
  // ------------------------------------------------------------------

  assign wr_ctl = WR && (ADDR == `SARCC_OFS_CONV_CONTROL);
  assign conv_on = converter_control_reg[`SARCC_CTL_ON];
  // Only an already enabled converter starts from software
  assign sw_start = wr_ctl && WDATA[`SARCC_CTL_GO] && conv_on && WDATA[`SARCC_CTL_ON]; // RQ9
  assign trig_match = CCU_TRIGGER && (CCU_MODE == `SARCC_CCU_MODE_TRIGGER);
  assign hw_start = trig_match && conv_on; // RQ10 RQ11
  assign start = (state_reg == ST_IDLE) && (sw_start || hw_start);

  // Channel and pin roles
  assign chan = converter_control_reg[`SARCC_CTL_CHAN_LO + 1:`SARCC_CTL_CHAN_LO];
  assign chan_valid = !converter_control_reg[`SARCC_CTL_CHAN_HI]; // RQ20
  assign pin_is_out = chan_valid && !port_a_direction_reg[chan]; // RQ13
  assign amask = analog_mask(analog_pin_config_reg[2:0]) & port_a_direction_reg[3:0]; // RQ15
  assign port_read = pa_sync_reg & ~{1'b0, amask}; // RQ12

  // ------------------------------------------------------------------
  // Bit period generator
  // ------------------------------------------------------------------

  sarcc_tad_gen #(
    .RC_TAD_NS(RC_TAD_NS)
  ) u_tad_gen (
    .clk(SYS_CLK),
    .resetn(RESETN),
    .run(state_reg == ST_CONV),
    .clk_sel(converter_control_reg[`SARCC_CTL_CLKSEL_HI:`SARCC_CTL_CLKSEL_LO]),
    .half_tick(half_tick)
  );

  // ------------------------------------------------------------------
  // Conversion sequencer
  // ------------------------------------------------------------------

  // Sample for 1.5 periods, then one decision per full period
  always @* begin
    state_next = state_reg;
    half_cnt_next = half_cnt_reg;
    sar_next = sar_reg;
    bit_mask_next = bit_mask_reg;
    done = 1'b0;
    // Output-driven pin converts its own latch level
    comp_eff = pin_is_out ? port_latch_reg[chan] : comp_sync_reg; // RQ13
    decide = half_tick && (half_cnt_reg > `SARCC_SAMPLE_HALVES) && !half_cnt_reg[0];
    case (state_reg)
      ST_IDLE: begin
        if (start) begin
          state_next = ST_CONV; // RQ14
          half_cnt_next = 5'h00;
          sar_next = 8'h00;
          bit_mask_next = 8'h80;
        end
      end
      ST_CONV: begin
        if (!conv_on) begin
          state_next = ST_IDLE;
        end else if (half_tick) begin
          half_cnt_next = half_cnt_reg + 5'h01;
          if (decide) begin
            sar_next = comp_eff ? (sar_reg | bit_mask_reg) : sar_reg;
            bit_mask_next = {1'b0, bit_mask_reg[7:1]};
          end
          if (half_cnt_reg + 5'h01 == `SARCC_HALF_TADS) begin
            state_next = ST_IDLE; // RQ3
            done = 1'b1;
          end
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  // Sequencer state; reset aborts any conversion
  always @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      state_reg <= ST_IDLE; // RQ19
      half_cnt_reg <= 5'h00;
      sar_reg <= 8'h00;
      bit_mask_reg <= 8'h00;
    end else begin
      state_reg <= state_next;
      half_cnt_reg <= half_cnt_next;
      sar_reg <= sar_next;
      bit_mask_reg <= bit_mask_next;
    end
  end

  // Result has no reset so it survives every reset
  always @(posedge SYS_CLK) begin
    if (done) begin
      conversion_result_reg <= sar_next; // RQ1 RQ2
    end
  end

  // ------------------------------------------------------------------
  // Register writes
  // ------------------------------------------------------------------

  // Control register; hardware owns the busy bit
  always @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      converter_control_reg <= `SARCC_RST_ZERO; // RQ19
    end else begin
      if (wr_ctl) begin
        converter_control_reg <= masked(WDATA, `SARCC_MASK_CONTROL);
        // Busy cannot be cleared by software mid conversion
        converter_control_reg[`SARCC_CTL_GO] <= (state_reg == ST_CONV) || start; // RQ21
      end else if (start) begin
        converter_control_reg[`SARCC_CTL_GO] <= 1'b1; // RQ10
      end else if (done || state_next == ST_IDLE) begin
        converter_control_reg[`SARCC_CTL_GO] <= 1'b0; // RQ1
      end
    end
  end

  // Flag register; completion wins over a clearing write
  always @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      peripheral_irq_flags_reg <= `SARCC_RST_ZERO;
    end else begin
      if (WR && ADDR == `SARCC_OFS_PERIPH_FLAGS) begin
        peripheral_irq_flags_reg <= masked(WDATA, `SARCC_MASK_FLAGS);
      end
      if (done) begin
        peripheral_irq_flags_reg[`SARCC_FLAG_CONV] <= 1'b1; // RQ1
      end
    end
  end

  // Plain storage registers
  always @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      port_latch_reg <= `SARCC_RST_ZERO;
      port_a_direction_reg <= `SARCC_RST_PORT_A_DIR;
      interrupt_control_reg <= `SARCC_RST_ZERO;
      peripheral_irq_enables_reg <= `SARCC_RST_ZERO;
      analog_pin_config_reg <= `SARCC_RST_ZERO; // RQ19
    end else if (WR) begin
      case (ADDR)
        `SARCC_OFS_PORT_A_PINS: begin
          port_latch_reg <= masked(WDATA, `SARCC_MASK_PORT_A);
        end
        `SARCC_OFS_PORT_A_DIR: begin
          port_a_direction_reg <= masked(WDATA, `SARCC_MASK_PORT_A);
        end
        `SARCC_OFS_IRQ_CONTROL, `SARCC_OFS_IRQ_CONTROL_HI: begin
          interrupt_control_reg <= WDATA;
        end
        `SARCC_OFS_PERIPH_ENABLES: begin
          peripheral_irq_enables_reg <= masked(WDATA, `SARCC_MASK_FLAGS);
        end
        `SARCC_OFS_PIN_CONFIG: begin
          analog_pin_config_reg <= masked(WDATA, `SARCC_MASK_PIN_CONFIG);
        end
        default: begin
        end
      endcase
    end
  end

  // ------------------------------------------------------------------
  // Register reads
  // ------------------------------------------------------------------

  // Read mux; unmapped addresses read as zero
  always @* begin
    case (ADDR)
      `SARCC_OFS_PORT_A_PINS: rdata_next = {3'h0, port_read}; // RQ12
      `SARCC_OFS_IRQ_CONTROL: rdata_next = interrupt_control_reg;
      `SARCC_OFS_IRQ_CONTROL_HI: rdata_next = interrupt_control_reg;
      `SARCC_OFS_PERIPH_FLAGS: rdata_next = peripheral_irq_flags_reg;
      `SARCC_OFS_CONV_RESULT: rdata_next = conversion_result_reg;
      `SARCC_OFS_CONV_CONTROL: rdata_next = converter_control_reg;
      `SARCC_OFS_PORT_A_DIR: rdata_next = port_a_direction_reg;
      `SARCC_OFS_PERIPH_ENABLES: rdata_next = peripheral_irq_enables_reg;
      `SARCC_OFS_PIN_CONFIG: rdata_next = analog_pin_config_reg;
      default: rdata_next = 8'h00;
    endcase
  end

  // Read data stands only in the cycle after the strobe
  always @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      RDATA <= 8'h00;
    end else if (RD) begin
      RDATA <= rdata_next;
    end else begin
      RDATA <= 8'h00;
    end
  end

  // ------------------------------------------------------------------
  // Registered outputs
  // ------------------------------------------------------------------

  // Pin drive, hold switch and converter front-end controls
  always @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      PA_OUT <= 5'h00;
      PA_OE <= 5'h00;
      DAC_CODE <= 8'h00;
      CHAN_SEL <= 2'h0;
      HOLD_CONNECT <= 1'b0;
      ANALOG_EN <= 4'h0;
      VREF_EXT <= 1'b0;
      TIMER_CLEAR <= 1'b0;
    end else begin
      PA_OUT <= port_latch_reg[4:0];
      PA_OE <= ~port_a_direction_reg[4:0];
      DAC_CODE <= sar_next | bit_mask_next;
      CHAN_SEL <= chan;
      // Hold capacitor tracks only while on and idle
      HOLD_CONNECT <= conv_on && chan_valid && (state_next == ST_IDLE); // RQ8
      ANALOG_EN <= amask; // RQ15
      VREF_EXT <= ext_ref(analog_pin_config_reg[2:0]) && port_a_direction_reg[3];
      // Timer cleared on every matching trigger, enabled or not
      TIMER_CLEAR <= trig_match; // RQ10 RQ11
    end
  end

endmodule // sarcc_top

// ---- verification/sarcc_analog_model.sv ----
// Model of the analog sources seen through the hold capacitor.
// Assumes the block drives channel, hold switch and trial code as registered levels.
`timescale 1ns/1ps
module sarcc_analog_model (
  // Selection and trial code from the block
  input wire [1:0] chan,
  input wire hold,
  input wire [7:0] dac,
  // Port pins as driven by the block
  input wire [4:0] pin_oe,
  input wire [4:0] pin_out,
  // Source levels, one byte per input
  input wire [31:0] levels,
  // Comparator decision
  output wire comp
);
  reg [7:0] held_reg;
  // Capacitor tracks only while connected, so a late source change is not seen
  always @* begin
    if (hold) begin
      held_reg = pin_oe[chan] ? {8{pin_out[chan]}} : levels[chan * 8 +: 8];
    end
  end
  // Comparator against the trial code
  assign comp = (held_reg >= dac);
endmodule // sarcc_analog_model

// ---- verification/sarcc_top_sva.sv ----
// Assertions on the converter control top level.
// Sees only top-level ports; shadows of three registers are kept here.
`timescale 1ns/1ps
module sarcc_top_sva (
  // Clock and reset
  input wire SYS_CLK,
  input wire RESETN,
  // Register port
  input wire [7:0] ADDR,
  input wire [7:0] WDATA,
  input wire WR,
  input wire RD,
  input wire [7:0] RDATA,
  // Pins and front end
  input wire [4:0] PA_OE,
  input wire [1:0] CHAN_SEL,
  input wire HOLD_CONNECT,
  input wire [3:0] ANALOG_EN,
  input wire VREF_EXT,
  // Trigger
  input wire CCU_TRIGGER,
  input wire [3:0] CCU_MODE,
  input wire TIMER_CLEAR
);
  reg [4:0] dir_reg;
  reg [2:0] cfg_reg;
  reg [1:0] chan_reg;
  reg [1:0] live_reg;
  reg [4:0] dir_q;
  reg [2:0] cfg_q;
  reg [1:0] chan_q;
  wire trig_b = CCU_TRIGGER && (CCU_MODE == 4'hB);
  wire sw_go = WR && (ADDR == 8'h1F) && WDATA[2] && WDATA[0];
  wire [3:0] mask = (cfg_reg == 3'h0) ? 4'hF : (cfg_reg < 3'h2) ? 4'h7 : (cfg_reg < 3'h4) ? 4'h3 :
    (cfg_reg < 3'h6) ? 4'h1 : 4'h0;
  // Shadows one edge old, so settled means no write in the last cycle
  wire settled = (live_reg == 2'h3) && (dir_q == dir_reg) && (cfg_q == cfg_reg) && (chan_q == chan_reg);
  // Shadows; live count skips the first edges while registered outputs catch up
  always @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      dir_reg <= 5'h1F;
      cfg_reg <= 3'h0;
      chan_reg <= 2'h0;
      live_reg <= 2'h0;
      dir_q <= 5'h1F;
      cfg_q <= 3'h0;
      chan_q <= 2'h0;
    end else begin
      if (live_reg != 2'h3) live_reg <= live_reg + 2'h1;
      dir_q <= dir_reg;
      cfg_q <= cfg_reg;
      chan_q <= chan_reg;
      if (WR && ADDR == 8'h85) dir_reg <= WDATA[4:0];
      if (WR && ADDR == 8'h9F) cfg_reg <= WDATA[2:0];
      if (WR && ADDR == 8'h1F) chan_reg <= WDATA[4:3];
    end
  end
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  a_timer_clear_pulse: assert property (@(posedge SYS_CLK) disable iff (!RESETN) trig_b |=> TIMER_CLEAR)
    else $error("timer clear missing after trigger");
  a_timer_clear_quiet: assert property (@(posedge SYS_CLK) disable iff (!RESETN) !trig_b |=> !TIMER_CLEAR)
    else $error("timer clear without trigger");
  a_trig_starts_conv: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    trig_b && HOLD_CONNECT |=> !HOLD_CONNECT [*8])
    else $error("trigger did not start a conversion");
  a_sw_start_hold: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    sw_go && HOLD_CONNECT |=> !HOLD_CONNECT [*8])
    else $error("hold still connected after start");
  a_conv_ends_bound: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    sw_go && HOLD_CONNECT && WDATA[7:6] == 2'h0 |-> ##[15:40] HOLD_CONNECT)
    else $error("fast conversion did not end in time");
  a_rdata_idle_zero: assert property (@(posedge SYS_CLK) disable iff (!RESETN) !RD |=> RDATA == 8'h00)
    else $error("read data without read");
  a_port_analog_zero: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    RD && ADDR == 8'h05 |=> (RDATA[3:0] & ANALOG_EN) == 4'h0)
    else $error("analog pin read as one");
  a_dir_drives_oe: assert property (@(posedge SYS_CLK) disable iff (!RESETN) settled |-> PA_OE == ~dir_reg)
    else $error("output enable differs from direction");
  a_pin_roles_map: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    settled |-> ANALOG_EN == (mask & dir_reg[3:0]) && (VREF_EXT == 1'b0 || cfg_reg[0]))
    else $error("pin roles differ from configuration");
  a_chan_sel_map: assert property (@(posedge SYS_CLK) disable iff (!RESETN) settled |-> CHAN_SEL == chan_reg)
    else $error("channel select differs from control");
endmodule // sarcc_top_sva
bind sarcc_top sarcc_top_sva i_sarcc_top_sva (.SYS_CLK(SYS_CLK), .RESETN(RESETN), .ADDR(ADDR), .WDATA(WDATA),
  .WR(WR), .RD(RD), .RDATA(RDATA), .PA_OE(PA_OE), .CHAN_SEL(CHAN_SEL), .HOLD_CONNECT(HOLD_CONNECT),
  .ANALOG_EN(ANALOG_EN), .VREF_EXT(VREF_EXT), .CCU_TRIGGER(CCU_TRIGGER), .CCU_MODE(CCU_MODE),
  .TIMER_CLEAR(TIMER_CLEAR));

// ---- verification/sarcc_top_tb.sv ----
// Self-checking bench for the converter control block.
// Assumes the analog model in its own file and a shortened RC bit period.
`timescale 1ns/1ps
module sarcc_top_tb;
  reg SYS_CLK, RESETN, WR, RD, CCU_TRIGGER;
  reg [7:0] ADDR, WDATA, d, res;
  reg [3:0] CCU_MODE;
  reg [4:0] pa_drv;
  reg [31:0] levels, seed;
  reg [1:0] ch;
  wire [7:0] RDATA, DAC_CODE;
  wire [4:0] PA_OUT, PA_OE, PA_IN;
  wire [1:0] CHAN_SEL;
  wire [3:0] ANALOG_EN;
  wire COMP_IN, HOLD_CONNECT, VREF_EXT, TIMER_CLEAR;
  integer mismatches, num_checks, i, n, h;
  localparam [95:0] RST_TAB = 96'h1F00_0C00_851F_8C00_9F00_4000;
  // Pin level: the block's driver wins where enabled
  assign PA_IN = (PA_OE & PA_OUT) | (~PA_OE & pa_drv);
  sarcc_top #(.RC_TAD_NS(400)) i_sarcc_top (.SYS_CLK(SYS_CLK), .RESETN(RESETN), .ADDR(ADDR), .WDATA(WDATA),
    .WR(WR), .RD(RD), .RDATA(RDATA), .PA_IN(PA_IN), .PA_OUT(PA_OUT), .PA_OE(PA_OE), .COMP_IN(COMP_IN),
    .DAC_CODE(DAC_CODE), .CHAN_SEL(CHAN_SEL), .HOLD_CONNECT(HOLD_CONNECT), .ANALOG_EN(ANALOG_EN),
    .VREF_EXT(VREF_EXT), .CCU_TRIGGER(CCU_TRIGGER), .CCU_MODE(CCU_MODE), .TIMER_CLEAR(TIMER_CLEAR));
  sarcc_analog_model i_sarcc_analog_model (.chan(CHAN_SEL), .hold(HOLD_CONNECT), .dac(DAC_CODE),
    .pin_oe(PA_OE), .pin_out(PA_OUT), .levels(levels), .comp(COMP_IN));
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function [31:0] xs(input [31:0] s);
    reg [31:0] x;
    begin
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      xs = x ^ (x << 5);
    end
  endfunction
  // Cycles per half bit period; RC entry follows the shortened parameter
  function integer half(input [1:0] s);
    half = (s == 2'h0) ? 1 : (s == 2'h1) ? 4 : (s == 2'h2) ? 16 : 2;
  endfunction
  function [3:0] amask(input [2:0] c);
    amask = (c == 3'h0) ? 4'hF : (c < 3'h2) ? 4'h7 : (c < 3'h4) ? 4'h3 : (c < 3'h6) ? 4'h1 : 4'h0;
  endfunction
  task chk(input string nm, input [7:0] seen, input [7:0] exp_v);
    num_checks = num_checks + 1;
    if (seen !== exp_v) begin
      mismatches = mismatches + 1;
      $display("mismatch %s expected %h seen %h", nm, exp_v, seen);
    end
  endtask
  task wr(input [7:0] a, input [7:0] v);
    @(posedge SYS_CLK);
    WR <= 1'b1;
    ADDR <= a;
    WDATA <= v;
    @(posedge SYS_CLK);
    WR <= 1'b0;
  endtask
  // Read data stands only in the cycle after the strobe
  task rd(input [7:0] a, output [7:0] v);
    @(posedge SYS_CLK);
    RD <= 1'b1;
    ADDR <= a;
    @(posedge SYS_CLK);
    RD <= 1'b0;
    #1 v = RDATA;
  endtask
  task wait_cy(input integer c);
    repeat (c) @(posedge SYS_CLK);
  endtask
  // Enable first, settle, start, then poll the busy bit
  task conv(input [1:0] sel, input [1:0] c);
    h = half(sel);
    wr(8'h1F, {sel, 1'b0, c, 3'h1});
    wait_cy(8 * h + 10);
    wr(8'h1F, {sel, 1'b0, c, 3'h5});
    n = 0;
    rd(8'h1F, d);
    chk("busy", d[2], 1'b1);
    while (d[2] === 1'b1 && n < 800) begin
      rd(8'h1F, d);
      n = n + 2;
    end
  endtask
  task complete_run;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Clock, watchdog, sequence
  // ----------------------------------------------------------------
  initial begin
    SYS_CLK = 1'b0;
    forever #50 SYS_CLK = ~SYS_CLK;
  end
  initial begin
    #(30000 * 100);
    mismatches = mismatches + 1;
    complete_run;
  end
  initial begin
    {RESETN, WR, RD, CCU_TRIGGER, ADDR, WDATA, CCU_MODE, pa_drv, levels} = 0;
    mismatches = 0;
    num_checks = 0;
    seed = 32'hdad0;
    wait_cy(16);
    RESETN <= 1'b1;
    // Reset values and an unmapped place
    for (i = 0; i < 6; i = i + 1) begin
      rd(RST_TAB[95 - 16 * i -: 8], d);
      chk("reset value", d, RST_TAB[87 - 16 * i -: 8]);
    end
    wr(8'h9F, 8'hFF);
    rd(8'h9F, d);
    chk("pin config mask", d, 8'h07);
    // Port reads under every pin configuration
    for (i = 0; i < 8; i = i + 1) begin
      wr(8'h9F, i[7:0]);
      seed = xs(seed);
      pa_drv <= seed[4:0];
      wait_cy(4);
      rd(8'h05, d);
      chk("port read", d, {3'h0, seed[4:0] & ~{1'b0, amask(i[2:0])}});
    end
    wr(8'h9F, 8'h00);
    // Arm converter and global interrupt enables before any start
    wr(8'h8C, 8'h40);
    wr(8'h0B, 8'hC0);
    rd(8'h8B, d);
    chk("irq control", d, 8'hC0);
    // One conversion per clock source, random level and channel
    for (i = 0; i < 4; i = i + 1) begin
      seed = xs(seed);
      @(posedge SYS_CLK);
      // Fastest select is below the minimum bit period: comparator lags, so rail level only
      levels <= (i == 0) ? 32'hFFFF_FFFF : seed;
      ch = seed[9:8];
      conv(i[1:0], ch);
      chk("duration", (n + 2 >= 19 * h) && (n + 2 <= 19 * h + 12), 1'b1);
      res = levels[ch * 8 +: 8];
      rd(8'h1E, d);
      chk("result", d, res);
      chk("trial code", DAC_CODE, res);
      rd(8'h0C, d);
      chk("done flag", d, 8'h40);
      wr(8'h0C, 8'h00);
      rd(8'h0C, d);
      chk("flag clear", d, 8'h00);
    end
    // Selected pin driven as output converts its own level
    wr(8'h85, 8'h1E);
    wr(8'h05, 8'h01);
    conv(2'h0, 2'h0);
    res = 8'hFF;
    rd(8'h1E, d);
    chk("output pin result", d, res);
    chk("pin drive", {PA_OE[3:0], PA_OUT[3:0]}, 8'h11);
    wr(8'h85, 8'h1F);
    wr(8'h0C, 8'h00);
    // Trigger while enabled, then every mode while disabled
    CCU_MODE <= 4'hB;
    // RC clock gives the comparator time to settle between decisions
    wr(8'h1F, 8'hC1);
    wait_cy(10);
    CCU_TRIGGER <= 1'b1;
    @(posedge SYS_CLK);
    CCU_TRIGGER <= 1'b0;
    rd(8'h1F, d);
    chk("trigger start", d, 8'hC5);
    wait_cy(40);
    res = levels[7:0];
    rd(8'h1E, d);
    chk("trigger result", d, res);
    wr(8'h1F, 8'h00);
    for (i = 0; i < 16; i = i + 1) begin
      CCU_MODE <= i[3:0];
      CCU_TRIGGER <= 1'b1;
      @(posedge SYS_CLK);
      CCU_TRIGGER <= 1'b0;
      rd(8'h1F, d);
      chk("trigger ignored", d, 8'h00);
    end
    // Abort by switching off mid-conversion
    wr(8'h0C, 8'h00);
    wr(8'h1F, 8'h41);
    wait_cy(50);
    wr(8'h1F, 8'h45);
    wait_cy(20);
    wr(8'h1F, 8'h40);
    rd(8'h1F, d);
    chk("abort busy", d, 8'h40);
    rd(8'h0C, d);
    chk("abort flag", d, 8'h00);
    // Reset in mid-conversion keeps the result
    wr(8'h1F, 8'h81);
    wait_cy(20);
    wr(8'h1F, 8'h85);
    wait_cy(20);
    RESETN <= 1'b0;
    wait_cy(2);
    RESETN <= 1'b1;
    rd(8'h1E, d);
    chk("result kept", d, res);
    rd(8'h1F, d);
    chk("control reset", d, 8'h00);
    complete_run;
  end
endmodule // sarcc_top_tb
